// ===== hid_sensor_pkg.sv
// Constants for the sensor report server: descriptor values, field
// widths, report numbers and stream lengths.
// Assumes nothing of its surroundings; holds definitions only.
package hid_sensor_pkg;

  // ----------------------------------------------------------------
  // Descriptor field values
  // ----------------------------------------------------------------
  localparam logic [15:0] DESC_LEN = 16'h001e; // Descriptor bytes
  localparam logic [15:0] PROTO_REV = 16'h0100; // Protocol revision
  localparam logic [15:0] RDESC_SIZE = 16'h0c8d; // Report desc bytes
  localparam logic [15:0] RDESC_ID = 16'h0002; // Report desc register
  localparam logic [15:0] INPUT_ID = 16'h0003; // Input report register
  localparam logic [15:0] MAX_IN = 16'h000d; // Max input length
  localparam logic [15:0] OUT_ID = 16'h0000; // No output register
  localparam logic [15:0] MAX_OUT = 16'h0000; // No output report
  localparam logic [15:0] CMD_ID = 16'h0005; // Command register
  localparam logic [15:0] DATA_ID = 16'h0006; // Data register
  localparam logic [15:0] HDESC_ID = 16'h0001; // Descriptor register
  localparam logic [15:0] MAKER_CODE = 16'h0a5a; // Arbitrary value
  localparam logic [15:0] PART_CODE = 16'h0123; // Arbitrary value
  localparam logic [15:0] REV_CODE = 16'h0001; // Arbitrary value

  // ----------------------------------------------------------------
  // Packed images, byte 0 in the low bits
  // ----------------------------------------------------------------
  localparam int VEC_W = 264; // Widest stream image
  localparam logic [VEC_W-1:0] HID_DESC = {24'h0, 32'h0, REV_CODE,
    PART_CODE, MAKER_CODE, DATA_ID, CMD_ID, MAX_OUT, OUT_ID, MAX_IN,
    INPUT_ID, RDESC_ID, RDESC_SIZE, PROTO_REV, DESC_LEN};
  // Six 16-bit label elements, one character each; arbitrary text
  localparam logic [95:0] SENSOR_LABEL = {16'h0045, 16'h0053,
    16'h004e, 16'h0045, 16'h0053, 16'h0058};
  localparam logic [7:0] LINK_TYPE = 8'h00; // Integrated sensor

  // ----------------------------------------------------------------
  // Report numbers and stream lengths
  // ----------------------------------------------------------------
  localparam logic [7:0] RPT_ACCEL = 8'h01;
  localparam logic [7:0] RPT_COMPASS = 8'h02;
  localparam logic [7:0] RPT_GYRO = 8'h03;
  localparam logic [7:0] RPT_INCL = 8'h04;
  localparam logic [7:0] RPT_ORIENT = 8'h05;
  localparam int IDX_W = 12; // Byte index width
  localparam logic [IDX_W-1:0] FEAT_BYTES = 12'h021; // With prefix
  localparam logic [IDX_W-1:0] PAY_SHAKE = 12'h00a; // Accel, gyro
  localparam logic [IDX_W-1:0] PAY_FOUR = 12'h00b; // Compass, quat
  localparam logic [IDX_W-1:0] PAY_INCL = 12'h009;
  localparam logic [IDX_W-1:0] PREFIX_BYTES = 12'h002;

  // Sensor kinds and byte sources
  typedef enum logic [2:0] {K_ACCEL, K_COMPASS, K_GYRO, K_INCL,
    K_ORIENT} sensor_kind_t;
  typedef enum logic [1:0] {SRC_DESC, SRC_RDESC, SRC_INPUT,
    SRC_FEAT} source_t;

endpackage : hid_sensor_pkg

// ===== pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes pins are asynchronous to i_clock; i_clk_en freezes it.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);

  // ----------------------------------------------------------------
  // One chain per bit
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_ff; // Only read by s2_ff
      logic s2_ff;
      logic s3_ff;
      logic lvl_ff; // Accepted level
      // Shift and accept once stages two and three agree
      always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
          s1_ff <= RST_VAL[g];
          s2_ff <= RST_VAL[g];
          s3_ff <= RST_VAL[g];
          lvl_ff <= RST_VAL[g];
        end else if (i_clk_en) begin
          s1_ff <= i_pin[g];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            lvl_ff <= s3_ff;
          end
        end
      end
      assign o_level[g] = lvl_ff;
    end
  endgenerate

endmodule : pin_sync

// ===== hid_sensor_report_server.sv
// Sensor report server: streams the fixed descriptor, the report
// descriptor, feature and input reports byte by byte to the host.
// Assumes an I2C target outside frames reads and writes by register id.
// Operation
// (R1) Descriptor length field reads 0x001e
// (R2) Protocol revision field reads 0x0100
// (R3) Report descriptor size reads 3213 bytes
// (R4) Report descriptor served at id 0x0002
// (R5) Input reports read at id 0x0003
// (R6) Maximum input size field reads 0x000d
// (R7) Output id and size both zero
// (R8) Commands written at id 0x0005
// (R9) Command data at id 0x0006
// (R10) Every sensor has feature and input reports
// (R11) Feature report field order fixed
// (R12) Feature report ends with six-element label
// (R13) Accelerometer report layout with shake byte
// (R14) Compass report: heading then field axes
// (R15) Gyroscope report layout with shake byte
// (R16) Inclinometer report: three angle values
// (R17) Orientation report: quaternion X,Y,Z,W
// (R18) Low alert while report data waits
// (R19) Host raises wake before any traffic
// (R20) Reset input clears host-facing logic; o_host_alert_n is not cleared by it
// (R21) Serial clock up to 400 kHz
// (R22) Multi-byte fields sent low byte first
// (R23) Alert held until input report read
`timescale 1ns/1ps
module hid_sensor_report_server (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_wake_request,
  input wire logic i_iface_reset_in_n,
  input wire logic i_rd_start,
  input wire logic [15:0] i_rd_id,
  input wire logic i_tx_ack,
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  output logic o_tx_last,
  output logic o_busy,
  input wire logic i_wr_valid,
  input wire logic [15:0] i_wr_id,
  input wire logic [7:0] i_wr_byte,
  output logic o_cmd_valid,
  output logic o_data_valid,
  output logic [7:0] o_wr_byte,
  output logic [11:0] o_rdesc_addr,
  input wire logic [7:0] i_rdesc_byte,
  input wire logic i_sample_valid,
  input wire logic [2:0] i_sample_kind,
  input wire logic [7:0] i_sample_state,
  input wire logic [7:0] i_sample_event,
  input wire logic [15:0] i_sample_v0,
  input wire logic [15:0] i_sample_v1,
  input wire logic [15:0] i_sample_v2,
  input wire logic [15:0] i_sample_v3,
  input wire logic [7:0] i_sample_shake,
  input wire logic [7:0] i_feat_number,
  input wire logic [7:0] i_feat_reporting,
  input wire logic [7:0] i_feat_power,
  input wire logic [7:0] i_feat_state,
  input wire logic [15:0] i_feat_period,
  input wire logic [15:0] i_feat_accuracy,
  input wire logic [15:0] i_feat_resolution,
  input wire logic [15:0] i_feat_threshold,
  input wire logic [15:0] i_feat_max,
  input wire logic [15:0] i_feat_min,
  input wire logic [15:0] i_feat_min_period,
  output logic o_host_alert_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int W = hid_sensor_pkg::VEC_W;
  localparam int IW = hid_sensor_pkg::IDX_W;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SEND} seq_t;

  seq_t state_ff; // Sequencer state
  hid_sensor_pkg::source_t src_ff; // Stream being served
  logic [IW-1:0] idx_ff; // Byte index in stream
  logic [IW-1:0] total_ff; // Stream length in bytes
  logic wake_lvl; // Filtered wake pin
  logic iface_rst_n_lvl; // Filtered interface reset pin
  logic [1:0] pin_lvl; // Synchroniser outputs

  // Latched sample, frozen while an input report goes out
  hid_sensor_pkg::sensor_kind_t kind_ff;
  logic [7:0] s_state_ff;
  logic [7:0] s_event_ff;
  logic [15:0] s_v0_ff;
  logic [15:0] s_v1_ff;
  logic [15:0] s_v2_ff;
  logic [15:0] s_v3_ff;
  logic [7:0] s_shake_ff;

  logic [W-1:0] feat_vec; // Feature report image
  logic [W-1:0] in_vec; // Input report image
  logic [IW-1:0] in_pay; // Input payload length
  logic [7:0] cur_byte; // Byte at idx_ff of current stream
  logic in_busy; // Input report being served
  logic capture; // Sample accepted this cycle
  logic in_done; // Input report fully read
  logic iface_clr; // Host interface held in reset
  logic tx_valid_ff;
  logic [7:0] tx_byte_ff;
  logic tx_last_ff;
  logic alert_n_ff;
  logic cmd_valid_ff;
  logic data_valid_ff;
  logic [7:0] wr_byte_ff;
  logic busy_ff; // Registered copy of state_ff != ST_IDLE

  // ----------------------------------------------------------------
  // Byte picker, shared by all streams except the report descriptor
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick(input logic [W-1:0] v,
                                      input logic [IW-1:0] i);
    logic [W-1:0] s;
    s = v >> {i[5:0], 3'b000};
    return s[7:0];
  endfunction : pick

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(
    .W(2),
    .RST_VAL(2'h2)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_pin({i_iface_reset_in_n, i_wake_request}),
    .o_level(pin_lvl)
  );
  assign wake_lvl = pin_lvl[0];
  assign iface_rst_n_lvl = pin_lvl[1];
  assign iface_clr = !iface_rst_n_lvl; // [R20]

  // ----------------------------------------------------------------
  // Report images, all fields low byte first
  // ----------------------------------------------------------------
  // Feature report: same layout for every sensor [R10]
  always_comb begin
    feat_vec = {hid_sensor_pkg::SENSOR_LABEL, // [R12]
      i_feat_min_period, i_feat_min, i_feat_max, // [R11]
      i_feat_threshold, i_feat_resolution, i_feat_accuracy,
      i_feat_period, i_feat_state, i_feat_power, i_feat_reporting,
      hid_sensor_pkg::LINK_TYPE, i_feat_number,
      4'h0, hid_sensor_pkg::FEAT_BYTES}; // [R22]
  end

  // Input report: length prefix, then the layout of the sensor kind
  always_comb begin
    in_vec = '0;
    in_pay = hid_sensor_pkg::PAY_SHAKE;
    case (kind_ff)
      hid_sensor_pkg::K_ACCEL: begin
        in_vec[95:16] = {s_shake_ff, s_v2_ff, s_v1_ff, s_v0_ff,
          s_event_ff, s_state_ff, hid_sensor_pkg::RPT_ACCEL}; // [R13]
      end
      hid_sensor_pkg::K_COMPASS: begin
        in_pay = hid_sensor_pkg::PAY_FOUR;
        in_vec[103:16] = {s_v3_ff, s_v2_ff, s_v1_ff, s_v0_ff,
          s_event_ff, s_state_ff, hid_sensor_pkg::RPT_COMPASS}; // [R14]
      end
      hid_sensor_pkg::K_GYRO: begin
        in_vec[95:16] = {s_shake_ff, s_v2_ff, s_v1_ff, s_v0_ff,
          s_event_ff, s_state_ff, hid_sensor_pkg::RPT_GYRO}; // [R15]
      end
      hid_sensor_pkg::K_INCL: begin
        in_pay = hid_sensor_pkg::PAY_INCL;
        in_vec[87:16] = {s_v2_ff, s_v1_ff, s_v0_ff,
          s_event_ff, s_state_ff, hid_sensor_pkg::RPT_INCL}; // [R16]
      end
      default: begin
        in_pay = hid_sensor_pkg::PAY_FOUR;
        in_vec[103:16] = {s_v3_ff, s_v2_ff, s_v1_ff, s_v0_ff,
          s_event_ff, s_state_ff, hid_sensor_pkg::RPT_ORIENT}; // [R17]
      end
    endcase
    in_vec[15:0] = {4'h0, in_pay + hid_sensor_pkg::PREFIX_BYTES};
  end

  // Byte of the stream at the current index
  always_comb begin
    case (src_ff)
      hid_sensor_pkg::SRC_DESC: cur_byte = pick(hid_sensor_pkg::HID_DESC,
                                                idx_ff); // [R2] [R22]
      hid_sensor_pkg::SRC_RDESC: cur_byte = i_rdesc_byte; // [R4]
      hid_sensor_pkg::SRC_INPUT: cur_byte = pick(in_vec, idx_ff);
      default: cur_byte = pick(feat_vec, idx_ff);
    endcase
  end

  // ----------------------------------------------------------------
  // Read sequencer
  // ----------------------------------------------------------------
  assign in_busy = (state_ff != ST_IDLE) &&
                   (src_ff == hid_sensor_pkg::SRC_INPUT);
  assign in_done = in_busy && (state_ff == ST_SEND) && i_tx_ack &&
                   tx_last_ff;

  // Id decode, byte stepping and abort on interface reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
      src_ff <= hid_sensor_pkg::SRC_DESC;
      idx_ff <= '0;
      total_ff <= '0;
      busy_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (iface_clr) begin
        state_ff <= ST_IDLE; // [R20]
        busy_ff <= 1'b0;
        idx_ff <= '0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            idx_ff <= '0;
            // Traffic only counts once the host has raised wake [R19]
            if (i_rd_start && wake_lvl) begin
              state_ff <= ST_FETCH;
              busy_ff <= 1'b1;
              case (i_rd_id)
                hid_sensor_pkg::HDESC_ID: begin
                  src_ff <= hid_sensor_pkg::SRC_DESC;
                  total_ff <= hid_sensor_pkg::DESC_LEN[IW-1:0]; // [R1]
                end
                hid_sensor_pkg::RDESC_ID: begin
                  src_ff <= hid_sensor_pkg::SRC_RDESC; // [R4]
                  total_ff <= hid_sensor_pkg::RDESC_SIZE[IW-1:0]; // [R3]
                end
                hid_sensor_pkg::INPUT_ID: begin
                  src_ff <= hid_sensor_pkg::SRC_INPUT; // [R5]
                  total_ff <= in_pay + hid_sensor_pkg::PREFIX_BYTES;
                end
                hid_sensor_pkg::DATA_ID: begin
                  src_ff <= hid_sensor_pkg::SRC_FEAT; // [R9]
                  total_ff <= hid_sensor_pkg::FEAT_BYTES;
                end
                default: begin
                  state_ff <= ST_IDLE; // Unknown id: no bytes
                  busy_ff <= 1'b0;
                end
              endcase
            end
          end
          ST_FETCH: begin
            state_ff <= ST_SEND;
          end
          ST_SEND: begin
            // One ack per byte; 400 kHz framing is far below i_clock [R21]
            if (i_tx_ack) begin
              if (tx_last_ff) begin
                state_ff <= ST_IDLE;
                busy_ff <= 1'b0;
              end else begin
                idx_ff <= idx_ff + 1'b1;
                state_ff <= ST_FETCH;
              end
            end
          end
          default: begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // Output byte register, loaded in the fetch cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_valid_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
      tx_last_ff <= 1'b0;
    end else if (i_clk_en) begin
      if (iface_clr) begin
        tx_valid_ff <= 1'b0;
        tx_last_ff <= 1'b0;
      end else if (state_ff == ST_FETCH) begin
        tx_valid_ff <= 1'b1;
        tx_byte_ff <= cur_byte;
        tx_last_ff <= (idx_ff == total_ff - 1'b1);
      end else if (state_ff == ST_SEND && i_tx_ack) begin
        tx_valid_ff <= 1'b0;
        tx_last_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample capture and alert
  // ----------------------------------------------------------------
  assign capture = i_sample_valid && !in_busy;

  // Latch the newest sample unless an input report is going out
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      kind_ff <= hid_sensor_pkg::K_ACCEL;
      s_state_ff <= 8'h00;
      s_event_ff <= 8'h00;
      s_v0_ff <= 16'h0000;
      s_v1_ff <= 16'h0000;
      s_v2_ff <= 16'h0000;
      s_v3_ff <= 16'h0000;
      s_shake_ff <= 8'h00;
    end else if (i_clk_en && capture) begin
      kind_ff <= hid_sensor_pkg::sensor_kind_t'(i_sample_kind);
      s_state_ff <= i_sample_state;
      s_event_ff <= i_sample_event;
      s_v0_ff <= i_sample_v0;
      s_v1_ff <= i_sample_v1;
      s_v2_ff <= i_sample_v2;
      s_v3_ff <= i_sample_v3;
      s_shake_ff <= i_sample_shake;
    end
  end

  // Alert low while a report waits; a sample in the release cycle is dropped
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alert_n_ff <= 1'b1;
    end else if (i_clk_en) begin
      if (capture) begin
        alert_n_ff <= 1'b0; // [R18]
      end else if (in_done) begin
        alert_n_ff <= 1'b1; // [R23]
      end
    end
  end

  // ----------------------------------------------------------------
  // Command and data register writes
  // ----------------------------------------------------------------
  // Forward host writes as one-cycle strobes
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_valid_ff <= 1'b0;
      data_valid_ff <= 1'b0;
      wr_byte_ff <= 8'h00;
    end else if (i_clk_en) begin
      cmd_valid_ff <= i_wr_valid && wake_lvl && !iface_clr &&
                      (i_wr_id == hid_sensor_pkg::CMD_ID); // [R8]
      data_valid_ff <= i_wr_valid && wake_lvl && !iface_clr &&
                       (i_wr_id == hid_sensor_pkg::DATA_ID); // [R9]
      if (i_wr_valid) begin
        wr_byte_ff <= i_wr_byte;
      end
    end
  end

  // Outputs straight from flip-flops
  assign o_tx_valid = tx_valid_ff;
  assign o_tx_byte = tx_byte_ff;
  assign o_tx_last = tx_last_ff;
  assign o_busy = busy_ff;
  assign o_rdesc_addr = idx_ff;
  assign o_host_alert_n = alert_n_ff;
  assign o_cmd_valid = cmd_valid_ff;
  assign o_data_valid = data_valid_ff;
  assign o_wr_byte = wr_byte_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  logic desc_on;
  assign desc_on = o_tx_valid && (src_ff == hid_sensor_pkg::SRC_DESC);

  desc_len_a: assert property ( // [R1]
    desc_on && idx_ff == 12'h000 |-> o_tx_byte == 8'h1e)
    else $error("descriptor length byte wrong");
  proto_rev_a: assert property ( // [R2]
    desc_on && idx_ff == 12'h003 |-> o_tx_byte == 8'h01)
    else $error("protocol revision byte wrong");
  rdesc_size_a: assert property ( // [R3]
    desc_on && idx_ff == 12'h004 |-> o_tx_byte == 8'h8d)
    else $error("report descriptor size byte wrong");
  max_in_a: assert property ( // [R6]
    desc_on && idx_ff == 12'h00a |-> o_tx_byte == 8'h0d)
    else $error("max input size byte wrong");
  no_output_a: assert property ( // [R7]
    desc_on && idx_ff >= 12'h00c && idx_ff <= 12'h00f
    |-> o_tx_byte == 8'h00)
    else $error("output report fields not zero");
  cmd_id_a: assert property ( // [R8]
    desc_on && idx_ff == 12'h010 |-> o_tx_byte == 8'h05)
    else $error("command id byte wrong");
  alert_set_a: assert property ( // [R18]
    i_clk_en && capture |=> !o_host_alert_n)
    else $error("alert not raised after sample");
  alert_clr_a: assert property ( // [R23]
    i_clk_en && in_done && !i_sample_valid |=> o_host_alert_n)
    else $error("alert not released after read");
  iface_rst_a: assert property ( // [R20]
    i_clk_en && iface_clr |=> !o_tx_valid && !o_busy)
    else $error("transfer not aborted by reset");

endmodule : hid_sensor_report_server

// ===== host_model.sv
// Host side model: starts reads and takes bytes one by one.
// Assumes the bench pulses i_go at a falling edge.
`timescale 1ns/1ps
module host_model (
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic [15:0] i_id,
  input wire logic i_slow,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_tx_last,
  output logic o_rd_start,
  output logic [15:0] o_rd_id,
  output logic o_tx_ack,
  output logic o_done
);
  logic [7:0] got [0:4095]; // Bytes taken in order
  int n_got; // Bytes taken so far
  logic wait_ff; // One stall cycle in slow mode
  initial begin
    o_rd_start = 1'b0;
    o_rd_id = 16'hffff;
    o_tx_ack = 1'b0;
    o_done = 1'b0;
    n_got = 0;
    wait_ff = 1'b0;
  end
  // ----------------------------------------------------------------
  // Request and take, all on the falling edge
  // ----------------------------------------------------------------
  always @(negedge i_clock) begin
    o_rd_start <= i_go;
    o_rd_id <= i_go ? i_id : ~o_rd_id; // Id line not held after start
    if (i_go) begin
      n_got <= 0;
      o_done <= 1'b0;
    end
    if (o_tx_ack) begin
      o_tx_ack <= 1'b0; // Ack is a one cycle pulse
      wait_ff <= 1'b0;
    end else if (i_tx_valid) begin
      if (i_slow && !wait_ff) begin
        wait_ff <= 1'b1; // Stall before taking
      end else begin
        o_tx_ack <= 1'b1;
        got[n_got] <= i_tx_byte;
        n_got <= n_got + 1;
        if (i_tx_last) o_done <= 1'b1;
      end
    end
  end
endmodule : host_model

// ===== hid_sensor_report_server_test.sv
// Self-checking bench for the sensor report server.
// Assumes host_model and the package are compiled first.
`timescale 1ns/1ps
module hid_sensor_report_server_test;
  logic clk = 1'b0, rst_n = 1'b0, wake = 1'b1, ifr_n = 1'b1;
  logic go = 1'b0, slow = 1'b0, wr_v = 1'b0, s_v = 1'b0;
  logic [15:0] id = '0, wr_id = '0;
  logic [7:0] wr_b = '0, s_st = '0, s_ev = '0, s_sh = '0;
  logic [2:0] s_k = '0;
  logic [15:0] sv [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
  logic en = 1'b1; // Clock enable, dropped once in t_cmd
  logic [7:0] fb [4] = '{8'h11, 8'h12, 8'h13, 8'h14}; // Feature bytes
  logic [15:0] fw [7] = '{16'h2221, 16'h2423, 16'h2625, 16'h2827,
    16'h7fff, 16'h8000, 16'h2a29}; // Feature words
  logic rd_start, ack, done, tx_v, tx_l, busy, cmd_v, dat_v, alert_n;
  logic [15:0] rd_id;
  logic [7:0] tx_b, wr_o;
  logic [11:0] ra;
  logic [7:0] ex [$]; // Expected byte stream
  int n_errors = 0, checks = 0;
  always #20 clk = ~clk;
  host_model host (.i_clock(clk), .i_go(go), .i_id(id), .i_slow(slow),
    .i_tx_valid(tx_v), .i_tx_byte(tx_b), .i_tx_last(tx_l),
    .o_rd_start(rd_start), .o_rd_id(rd_id), .o_tx_ack(ack), .o_done(done));
  hid_sensor_report_server dut (.i_clock(clk), .i_rst_n(rst_n),
    .i_clk_en(en), .i_wake_request(wake), .i_iface_reset_in_n(ifr_n),
    .i_rd_start(rd_start), .i_rd_id(rd_id), .i_tx_ack(ack),
    .o_tx_valid(tx_v), .o_tx_byte(tx_b), .o_tx_last(tx_l), .o_busy(busy),
    .i_wr_valid(wr_v), .i_wr_id(wr_id), .i_wr_byte(wr_b),
    .o_cmd_valid(cmd_v), .o_data_valid(dat_v), .o_wr_byte(wr_o),
    .o_rdesc_addr(ra), .i_rdesc_byte(ra[7:0] ^ 8'h5a),
    .i_sample_valid(s_v), .i_sample_kind(s_k), .i_sample_state(s_st),
    .i_sample_event(s_ev), .i_sample_v0(sv[0]), .i_sample_v1(sv[1]),
    .i_sample_v2(sv[2]), .i_sample_v3(sv[3]), .i_sample_shake(s_sh),
    .i_feat_number(fb[0]), .i_feat_reporting(fb[1]),
    .i_feat_power(fb[2]), .i_feat_state(fb[3]), .i_feat_period(fw[0]),
    .i_feat_accuracy(fw[1]), .i_feat_resolution(fw[2]),
    .i_feat_threshold(fw[3]), .i_feat_max(fw[4]),
    .i_feat_min(fw[5]), .i_feat_min_period(fw[6]),
    .o_host_alert_n(alert_n));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string w, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask : chk
  task automatic put16(input logic [15:0] v);
    ex.push_back(v[7:0]); // Low byte first
    ex.push_back(v[15:8]);
  endtask : put16
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Read one stream through the host and compare with ex
  task automatic rd(input logic [15:0] i, input logic s);
    go <= 1'b1;
    id <= i;
    slow <= s;
    cyc(2);
    go <= 1'b0;
    for (int t = 0; t < 20000 && !done; t++) cyc(1);
    chk("count", 16'(ex.size()), 16'(host.n_got));
    for (int j = 0; j < ex.size(); j++) chk("byte", ex[j], host.got[j]);
    ex.delete();
    cyc(2);
  endtask : rd
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_desc;
    logic [15:0] d [15] = '{16'h001e, 16'h0100, 16'h0c8d, 16'h0002,
      16'h0003, 16'h000d, 16'h0000, 16'h0000, 16'h0005, 16'h0006,
      hid_sensor_pkg::MAKER_CODE, hid_sensor_pkg::PART_CODE,
      hid_sensor_pkg::REV_CODE, 16'h0000, 16'h0000};
    foreach (d[j]) put16(d[j]);
    rd(16'h0001, 1'b0);
    $display("descriptor test done");
  endtask : t_desc
  task automatic t_feat;
    put16(16'(hid_sensor_pkg::FEAT_BYTES));
    ex.push_back(fb[0]);
    ex.push_back(hid_sensor_pkg::LINK_TYPE);
    for (int j = 1; j < 4; j++) ex.push_back(fb[j]);
    foreach (fw[j]) put16(fw[j]);
    for (int j = 0; j < 6; j++) put16(hid_sensor_pkg::SENSOR_LABEL[16*j+:16]);
    rd(16'h0006, 1'b1);
    $display("feature test done");
  endtask : t_feat
  task automatic t_input;
    for (int k = 0; k < 5; k++) begin
      foreach (sv[j]) sv[j] <= 16'hc000 | 16'(k << 4) | 16'(j);
      s_k <= 3'(k);
      s_st <= 8'h30 + 8'(k);
      s_ev <= 8'h40 + 8'(k);
      s_sh <= 8'h50 + 8'(k);
      s_v <= 1'b1;
      cyc(1);
      s_v <= 1'b0;
      cyc(1);
      chk("alert low", 16'h0, 16'(alert_n));
      put16((k == 3) ? 16'd11 : (k == 1 || k == 4) ? 16'd13 : 16'd12);
      ex.push_back(8'(k + 1));
      ex.push_back(8'h30 + 8'(k));
      ex.push_back(8'h40 + 8'(k));
      for (int j = 0; j < 3; j++) put16(16'hc000 | 16'(k << 4) | 16'(j));
      if (k == 1 || k == 4) put16(16'hc003 | 16'(k << 4));
      if (k == 0 || k == 2) ex.push_back(8'h50 + 8'(k));
      rd(16'h0003, k[0]);
      chk("alert free", 16'h1, 16'(alert_n));
    end
    $display("input test done");
  endtask : t_input
  task automatic t_rdesc;
    for (int j = 0; j < 3213; j++) ex.push_back(8'(j) ^ 8'h5a);
    rd(16'h0002, 1'b0);
    $display("report descriptor test done");
  endtask : t_rdesc
  task automatic t_cmd;
    go <= 1'b1;
    id <= 16'h0005;
    cyc(1);
    go <= 1'b0;
    cyc(5);
    chk("refused busy", 16'h0, 16'(busy));
    for (int j = 5; j < 7; j++) begin
      wr_v <= 1'b1;
      wr_id <= 16'(j);
      wr_b <= 8'ha0 + 8'(j);
      cyc(1);
      wr_v <= 1'b0;
      chk("cmd", 16'(j == 5), 16'(cmd_v));
      chk("data", 16'(j == 6), 16'(dat_v));
      chk("wbyte", 16'h00a0 + 16'(j), 16'(wr_o));
      cyc(1);
      chk("pulse end", 16'h0, 16'({cmd_v, dat_v}));
    end
    en <= 1'b0; // Frozen clock: a data write must leave no strobe
    wr_v <= 1'b1;
    cyc(1);
    chk("frozen", 16'h0, 16'(dat_v));
    en <= 1'b1;
    wr_v <= 1'b0;
    $display("command test done");
  endtask : t_cmd
  task automatic t_abort;
    go <= 1'b1;
    id <= 16'h0001;
    cyc(1);
    go <= 1'b0;
    cyc(8);
    chk("abort start", 16'h1, 16'(busy));
    ifr_n <= 1'b0;
    cyc(8);
    chk("abort valid", 16'h0, 16'(tx_v));
    chk("abort busy", 16'h0, 16'(busy));
    ifr_n <= 1'b1;
    cyc(8);
    $display("abort test done");
  endtask : t_abort
  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    #(40 * 40000);
    n_errors++;
    results();
  end
  initial begin
    cyc(6);
    rst_n <= 1'b1; // Wake held high well before traffic
    cyc(6);
    t_desc();
    t_feat();
    t_input();
    t_rdesc();
    t_cmd();
    t_abort();
    results();
  end
endmodule : hid_sensor_report_server_test
